// ==== logic/tdmhp_pkg.sv ====
// Constants and types of the switch host port
// Notes on behaviour
// - Port: 8-bit data, six address, four controls
// - Control and connect memories RW, data memory RO
// - Connect memory acknowledge within 800 ns
// - Data memory acknowledge within 1220 ns
// - A5, A1, A0 low address control register
// - A5 high: low five bits pick channel
// - Stream select bits supply upper address
// - Memory select: reserved, data, low, high
// - Split access: reads data, writes low
// - Split clear: memory select alone decides
// - Global force: every channel message and driven
// - Drive pin low tristates; else per-channel enable
// - High bit 1 sent serially, 256 per frame
// - Control bit goes one channel ahead
// - Within channel time, bits ordered by stream
// - Per-channel delay mode bit is honoured
// - High bit 6: low variable, high constant
// - Channel data fetched in preceding slot
package tdmhp_pkg;
  localparam int CLK_PERIOD_NS  = 100;
  localparam int ACK_CM_MAX_NS  = 800;
  localparam int ACK_DM_MAX_NS  = 1220;
  localparam int ACK_CM_RAW     = ACK_CM_MAX_NS / CLK_PERIOD_NS;
  localparam int ACK_DM_RAW     = ACK_DM_MAX_NS / CLK_PERIOD_NS;
  localparam int ACK_CM_MAX_CYC = (ACK_CM_RAW < 1) ? 1 : ACK_CM_RAW;
  localparam int ACK_DM_MAX_CYC = (ACK_DM_RAW < 1) ? 1 : ACK_DM_RAW;

  localparam int DATA_W   = 8;
  localparam int ADDR_W   = 6;
  localparam int CHAN_W   = 5;
  localparam int STREAM_W = 3;
  localparam int IDX_W    = 8;
  localparam int STREAMS  = 8;
  localparam int WAIT_W   = 4;

  localparam int ADDR_PAGE_BIT = 5;
  localparam int ADDR_A1_BIT   = 1;
  localparam int ADDR_A0_BIT   = 0;

  localparam int CTRL_SPLIT_BIT = 7;
  localparam int CTRL_FORCE_BIT = 6;
  localparam int CTRL_MSEL_HI   = 4;
  localparam int CTRL_MSEL_LO   = 3;
  localparam int CTRL_SSEL_HI   = 2;
  localparam int CTRL_SSEL_LO   = 0;
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO  = 8'h00;

  localparam int CMH_OE_BIT    = 0;
  localparam int CMH_CTL_BIT   = 1;
  localparam int CMH_MSG_BIT   = 2;
  localparam int CMH_DELAY_BIT = 6;

  typedef enum logic [1:0] {
    MSEL_RSVD = 2'h0,
    MSEL_DM   = 2'h1,
    MSEL_CML  = 2'h2,
    MSEL_CMH  = 2'h3
  } tdmhp_msel_t;
endpackage

// ==== logic/tdmhp_fetch_if.sv ====
// Fetch path between the TDM sequencer and the memories
`timescale 1ns/1ps
interface tdmhp_fetch_if;
  logic                          fetch_req;
  logic [tdmhp_pkg::STREAM_W-1:0] fetch_stream;
  logic [tdmhp_pkg::CHAN_W-1:0]   fetch_chan;
  logic [tdmhp_pkg::DATA_W-1:0]   cmh_data;
  logic [tdmhp_pkg::DATA_W-1:0]   cml_data;
  logic [tdmhp_pkg::DATA_W-1:0]   dm_data;

  modport seq (output fetch_req, output fetch_stream, output fetch_chan,
               input cmh_data, input cml_data, input dm_data);
  modport mem (input fetch_req, input fetch_stream, input fetch_chan,
               output cmh_data, output cml_data, output dm_data);
endinterface

// ==== logic/tdmhp_tdm_seq.sv ====
// Channel sequencer: fetch ahead, per-stream controls, serial control bits
`timescale 1ns/1ps
module tdmhp_tdm_seq (
  input  wire logic                    clk_in,
  input  wire logic                    reset_in,
  input  wire logic                    tick_in,
  input  wire logic                    frame_in,
  input  wire logic                    ode_in,
  input  wire logic                    force_in,
  tdmhp_fetch_if.seq                   f,
  output logic                         serial_out,
  output logic [8*tdmhp_pkg::STREAMS-1:0] byte_out,
  output logic [tdmhp_pkg::STREAMS-1:0] drive_out,
  output logic [tdmhp_pkg::STREAMS-1:0] msg_out,
  output logic [tdmhp_pkg::STREAMS-1:0] delay_out
);
  localparam int NS = tdmhp_pkg::STREAMS;
  localparam int W  = tdmhp_pkg::DATA_W;

  logic [tdmhp_pkg::CHAN_W-1:0]   chan_reg, chan_next, pos_chan;
  logic [tdmhp_pkg::STREAM_W-1:0] slot_reg, slot_next, pos_slot;
  logic                           ctl_reg, ctl_next;
  logic [NS-1:0][W-1:0]           pbyte_reg, pbyte_next, abyte_reg, abyte_next;
  logic [NS-1:0]                  pmsg_reg, pmsg_next, amsg_reg, amsg_next;
  logic [NS-1:0]                  poe_reg, poe_next, aoe_reg, aoe_next;
  logic [NS-1:0]                  pdly_reg, pdly_next, adly_reg, adly_next;
  logic [NS-1:0]                  drv_reg, drv_next;
  logic                           msg_eff;

  // ---------------------------------------------
  // Position and fetch one channel ahead
  // ---------------------------------------------
  assign pos_chan       = frame_in ? '0 : chan_reg;
  assign pos_slot       = frame_in ? '0 : slot_reg;
  assign f.fetch_req    = tick_in;
  assign f.fetch_stream = pos_slot;
  assign f.fetch_chan   = tdmhp_pkg::CHAN_W'(pos_chan + 1'b1);
  assign msg_eff        = force_in | f.cmh_data[tdmhp_pkg::CMH_MSG_BIT];

  always_comb begin
    {chan_next, slot_next} = {chan_reg, slot_reg};
    ctl_next   = ctl_reg;
    pbyte_next = pbyte_reg;
    pmsg_next  = pmsg_reg;
    poe_next   = poe_reg;
    pdly_next  = pdly_reg;
    abyte_next = abyte_reg;
    amsg_next  = amsg_reg;
    aoe_next   = aoe_reg;
    adly_next  = adly_reg;
    if (tick_in) begin
      {chan_next, slot_next} = 8'({pos_chan, pos_slot} + 1'b1);
      ctl_next = f.cmh_data[tdmhp_pkg::CMH_CTL_BIT];
      if (pos_slot == '0) begin
        abyte_next = pbyte_reg;
        amsg_next  = pmsg_reg;
        aoe_next   = poe_reg;
        adly_next  = pdly_reg;
      end
      pbyte_next[pos_slot] = msg_eff ? f.cml_data : f.dm_data;
      pmsg_next[pos_slot]  = msg_eff;
      poe_next[pos_slot]   = force_in | f.cmh_data[tdmhp_pkg::CMH_OE_BIT];
      pdly_next[pos_slot]  = f.cmh_data[tdmhp_pkg::CMH_DELAY_BIT];
    end
    drv_next = ode_in ? aoe_reg : '0;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      chan_reg  <= '0;
      slot_reg  <= '0;
      ctl_reg   <= 1'b0;
      pbyte_reg <= '0;
      pmsg_reg  <= '0;
      poe_reg   <= '0;
      pdly_reg  <= '0;
      abyte_reg <= '0;
      amsg_reg  <= '0;
      aoe_reg   <= '0;
      adly_reg  <= '0;
      drv_reg   <= '0;
    end else begin
      chan_reg  <= chan_next;
      slot_reg  <= slot_next;
      ctl_reg   <= ctl_next;
      pbyte_reg <= pbyte_next;
      pmsg_reg  <= pmsg_next;
      poe_reg   <= poe_next;
      pdly_reg  <= pdly_next;
      abyte_reg <= abyte_next;
      amsg_reg  <= amsg_next;
      aoe_reg   <= aoe_next;
      adly_reg  <= adly_next;
      drv_reg   <= drv_next;
    end
  end

  assign serial_out = ctl_reg;
  assign byte_out   = abyte_reg;
  assign drive_out  = drv_reg;
  assign msg_out    = amsg_reg;
  assign delay_out  = adly_reg;

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  chk_ctl_bit_out: assert property (@(posedge clk_in) disable iff (reset_in)
    tick_in |=> serial_out == $past(f.cmh_data[tdmhp_pkg::CMH_CTL_BIT]))
    else $error("serial control bit wrong");
  chk_stream_order: assert property (@(posedge clk_in) disable iff (reset_in)
    tick_in && !frame_in && chan_reg == 5'h1f && slot_reg == 3'h0
      |-> f.fetch_chan == 5'h00 && f.fetch_stream == 3'h0)
    else $error("control bit order wrong");
  chk_force_msg: assert property (@(posedge clk_in) disable iff (reset_in)
    tick_in && force_in |=> pmsg_reg[$past(f.fetch_stream)] && poe_reg[$past(f.fetch_stream)])
    else $error("force not applied");
  chk_switch_src: assert property (@(posedge clk_in) disable iff (reset_in)
    tick_in && !force_in && !f.cmh_data[tdmhp_pkg::CMH_MSG_BIT]
      |=> pbyte_reg[$past(f.fetch_stream)] == $past(f.dm_data))
    else $error("switched source wrong");
  chk_commit: assert property (@(posedge clk_in) disable iff (reset_in)
    tick_in && pos_slot == 3'h0 |=> abyte_reg == $past(pbyte_reg)
      ##1 drive_out == ($past(ode_in) ? $past(aoe_reg) : 8'h00))
    else $error("channel commit wrong");
  chk_ode_off: assert property (@(posedge clk_in) disable iff (reset_in)
    !ode_in |=> drive_out == 8'h00)
    else $error("drivers not released");
  chk_delay_bit: assert property (@(posedge clk_in) disable iff (reset_in)
    tick_in |=> pdly_reg[$past(f.fetch_stream)] == $past(f.cmh_data[tdmhp_pkg::CMH_DELAY_BIT]))
    else $error("delay mode bit wrong");
endmodule

// ==== logic/tdmhp_host_port.sv ====
// Host port top: control register, memories and host handshake
`timescale 1ns/1ps
module tdmhp_host_port (
  input  wire logic                          clk_in,
  input  wire logic                          reset_in,
  input  wire logic [tdmhp_pkg::ADDR_W-1:0]  host_address_inputs_in,
  input  wire logic [tdmhp_pkg::DATA_W-1:0]  host_data_bus_in,
  output logic      [tdmhp_pkg::DATA_W-1:0]  host_data_bus_out,
  output logic                               host_data_bus_oe_out,
  input  wire logic                          chip_select_n_in,
  input  wire logic                          data_strobe_n_in,
  input  wire logic                          read_write_in,
  output logic                               data_acknowledge_n_out,
  input  wire logic                          tdm_bit_tick_in,
  input  wire logic                          frame_pulse_in,
  input  wire logic                          global_output_drive_in,
  input  wire logic                          dm_write_en_in,
  input  wire logic [tdmhp_pkg::IDX_W-1:0]   dm_write_addr_in,
  input  wire logic [tdmhp_pkg::DATA_W-1:0]  dm_write_data_in,
  output logic                               serial_channel_control_out,
  output logic [8*tdmhp_pkg::STREAMS-1:0]    stream_byte_out,
  output logic [tdmhp_pkg::STREAMS-1:0]      stream_drive_en_out,
  output logic [tdmhp_pkg::STREAMS-1:0]      stream_msg_mode_out,
  output logic [tdmhp_pkg::STREAMS-1:0]      stream_const_delay_out
);
  localparam int W     = tdmhp_pkg::DATA_W;
  localparam int DEPTH = 1 << tdmhp_pkg::IDX_W;
  localparam logic [tdmhp_pkg::WAIT_W-1:0] ACK_CM_LIM = tdmhp_pkg::WAIT_W'(tdmhp_pkg::ACK_CM_MAX_CYC - 2);
  localparam logic [tdmhp_pkg::WAIT_W-1:0] ACK_DM_LIM = tdmhp_pkg::WAIT_W'(tdmhp_pkg::ACK_DM_MAX_CYC - 2);

  typedef enum logic [1:0] {
    HP_IDLE,
    HP_WAIT,
    HP_DONE
  } tdmhp_state_t;

  // ---------------------------------------------
  // Target decode
  // ---------------------------------------------
  function automatic tdmhp_pkg::tdmhp_msel_t host_target(
    input logic [W-1:0] ctrl,
    input logic         is_read
  );
    tdmhp_pkg::tdmhp_msel_t t;
    t = tdmhp_pkg::tdmhp_msel_t'(ctrl[tdmhp_pkg::CTRL_MSEL_HI:tdmhp_pkg::CTRL_MSEL_LO]);
    if (ctrl[tdmhp_pkg::CTRL_SPLIT_BIT]) begin
      t = is_read ? tdmhp_pkg::MSEL_DM : tdmhp_pkg::MSEL_CML;
    end
    return t;
  endfunction

  // ---------------------------------------------
  // Storage
  // ---------------------------------------------
  logic [W-1:0] cmh_mem [DEPTH];
  logic [W-1:0] cml_mem [DEPTH];
  logic [W-1:0] dm_mem  [DEPTH];

  tdmhp_state_t                   hp_reg, hp_next;
  logic [W-1:0]                   ctrl_reg, ctrl_next;
  logic [W-1:0]                   rdata_reg, rdata_next;
  logic [tdmhp_pkg::WAIT_W-1:0]   wait_reg, wait_next;
  logic                           cml_we;
  logic                           cmh_we;
  logic                           strobe;
  logic                           ctrl_hit;
  logic                           page_hit;
  logic                           mem_go;
  logic [tdmhp_pkg::IDX_W-1:0]    host_idx;
  logic [tdmhp_pkg::IDX_W-1:0]    fetch_idx;
  tdmhp_pkg::tdmhp_msel_t         tgt;

  tdmhp_fetch_if fetch_bus ();

  // ---------------------------------------------
  // Address decode
  // ---------------------------------------------
  assign strobe   = !chip_select_n_in && !data_strobe_n_in;
  assign page_hit = host_address_inputs_in[tdmhp_pkg::ADDR_PAGE_BIT];
  assign ctrl_hit = !page_hit
                    && !host_address_inputs_in[tdmhp_pkg::ADDR_A1_BIT]
                    && !host_address_inputs_in[tdmhp_pkg::ADDR_A0_BIT];
  assign host_idx = {ctrl_reg[tdmhp_pkg::CTRL_SSEL_HI:tdmhp_pkg::CTRL_SSEL_LO],
                     host_address_inputs_in[tdmhp_pkg::CHAN_W-1:0]};
  assign tgt      = host_target(ctrl_reg, read_write_in);
  // Host memory slot only when the sequencer leaves the cycle free
  assign mem_go   = (hp_reg == HP_WAIT) && strobe && !fetch_bus.fetch_req;

  // ---------------------------------------------
  // Host handshake
  // ---------------------------------------------
  always_comb begin
    hp_next    = hp_reg;
    ctrl_next  = ctrl_reg;
    rdata_next = rdata_reg;
    wait_next  = wait_reg;
    cml_we     = 1'b0;
    cmh_we     = 1'b0;
    case (hp_reg)
      HP_IDLE: begin
        wait_next = '0;
        if (strobe) begin
          if (ctrl_hit) begin
            if (read_write_in) begin
              rdata_next = ctrl_reg;
            end else begin
              ctrl_next = host_data_bus_in;
            end
            hp_next = HP_DONE;
          end else if (!page_hit) begin
            // Unused low addresses answer zero and ignore writes
            rdata_next = tdmhp_pkg::DATA_ZERO;
            hp_next    = HP_DONE;
          end else begin
            hp_next = HP_WAIT;
          end
        end
      end
      HP_WAIT: begin
        wait_next = tdmhp_pkg::WAIT_W'(wait_reg + 1'b1);
        if (!strobe) begin
          hp_next = HP_IDLE;
        end else if (mem_go) begin
          if (read_write_in) begin
            case (tgt)
              tdmhp_pkg::MSEL_DM:  rdata_next = dm_mem[host_idx];
              tdmhp_pkg::MSEL_CML: rdata_next = cml_mem[host_idx];
              tdmhp_pkg::MSEL_CMH: rdata_next = cmh_mem[host_idx];
              default:             rdata_next = tdmhp_pkg::DATA_ZERO;
            endcase
          end else begin
            // Data memory and reserved selection drop writes
            cml_we = (tgt == tdmhp_pkg::MSEL_CML);
            cmh_we = (tgt == tdmhp_pkg::MSEL_CMH);
          end
          hp_next = HP_DONE;
        end
      end
      HP_DONE: begin
        if (!strobe) begin
          hp_next = HP_IDLE;
        end
      end
      default: begin
        hp_next = HP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      hp_reg    <= HP_IDLE;
      ctrl_reg  <= tdmhp_pkg::CTRL_RESET;
      rdata_reg <= tdmhp_pkg::DATA_ZERO;
      wait_reg  <= '0;
    end else begin
      hp_reg    <= hp_next;
      ctrl_reg  <= ctrl_next;
      rdata_reg <= rdata_next;
      wait_reg  <= wait_next;
    end
  end

  assign data_acknowledge_n_out = (hp_reg != HP_DONE);
  assign host_data_bus_out      = rdata_reg;
  assign host_data_bus_oe_out   = (hp_reg == HP_DONE) && strobe && read_write_in;

  // ---------------------------------------------
  // Memory writes
  // ---------------------------------------------
  always_ff @(posedge clk_in) begin
    if (cml_we) begin
      cml_mem[host_idx] <= host_data_bus_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (cmh_we) begin
      cmh_mem[host_idx] <= host_data_bus_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (dm_write_en_in) begin
      dm_mem[dm_write_addr_in] <= dm_write_data_in;
    end
  end

  // ---------------------------------------------
  // Sequencer fetch port
  // ---------------------------------------------
  assign fetch_idx          = {fetch_bus.fetch_stream, fetch_bus.fetch_chan};
  assign fetch_bus.cmh_data = cmh_mem[fetch_idx];
  assign fetch_bus.cml_data = cml_mem[fetch_idx];
  assign fetch_bus.dm_data  = dm_mem[fetch_bus.cml_data];

  tdmhp_tdm_seq u_seq (
    .clk_in     (clk_in),
    .reset_in   (reset_in),
    .tick_in    (tdm_bit_tick_in),
    .frame_in   (frame_pulse_in),
    .ode_in     (global_output_drive_in),
    .force_in   (ctrl_reg[tdmhp_pkg::CTRL_FORCE_BIT]),
    .f          (fetch_bus.seq),
    .serial_out (serial_channel_control_out),
    .byte_out   (stream_byte_out),
    .drive_out  (stream_drive_en_out),
    .msg_out    (stream_msg_mode_out),
    .delay_out  (stream_const_delay_out)
  );

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  chk_ack_cm_bound: assert property (@(posedge clk_in) disable iff (reset_in)
    hp_reg == HP_WAIT && tgt != tdmhp_pkg::MSEL_DM |-> wait_reg < ACK_CM_LIM)
    else $error("connect memory ack late");
  chk_ack_dm_bound: assert property (@(posedge clk_in) disable iff (reset_in)
    hp_reg == HP_WAIT && tgt == tdmhp_pkg::MSEL_DM |-> wait_reg < ACK_DM_LIM)
    else $error("data memory ack late");
  chk_bus_drive: assert property (@(posedge clk_in) disable iff (reset_in)
    host_data_bus_oe_out |-> strobe && read_write_in && !data_acknowledge_n_out)
    else $error("bus driven outside read");
  chk_ack_release: assert property (@(posedge clk_in) disable iff (reset_in)
    !data_acknowledge_n_out && !strobe |=> data_acknowledge_n_out)
    else $error("ack held after strobe");
  chk_ctrl_write: assert property (@(posedge clk_in) disable iff (reset_in)
    hp_reg == HP_IDLE && strobe && ctrl_hit && !read_write_in
      |=> ctrl_reg == $past(host_data_bus_in) && !data_acknowledge_n_out)
    else $error("control write lost");
  chk_split_write: assert property (@(posedge clk_in) disable iff (reset_in)
    mem_go && !read_write_in && ctrl_reg[tdmhp_pkg::CTRL_SPLIT_BIT] |-> cml_we && !cmh_we)
    else $error("split write misrouted");
  chk_dm_readonly: assert property (@(posedge clk_in) disable iff (reset_in)
    mem_go && !read_write_in && tgt == tdmhp_pkg::MSEL_DM |-> !cml_we && !cmh_we)
    else $error("data memory written");
  chk_msel_high: assert property (@(posedge clk_in) disable iff (reset_in)
    mem_go && !read_write_in && !ctrl_reg[tdmhp_pkg::CTRL_SPLIT_BIT]
      && ctrl_reg[tdmhp_pkg::CTRL_MSEL_HI:tdmhp_pkg::CTRL_MSEL_LO] == 2'h3 |-> cmh_we)
    else $error("high memory write missed");
endmodule

// ==== sim/tdmhp_host_model.sv ====
// Host processor model for the non-multiplexed parallel port
`timescale 1ns/1ps
module tdmhp_host_model (
  input  wire logic       clk_in,
  input  wire logic       ack_n_in,
  input  wire logic       oe_in,
  input  wire logic [7:0] rdata_in,
  output logic      [5:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            cs_n_out,
  output logic            ds_n_out,
  output logic            rw_out
);
  initial begin
    cs_n_out  = 1'b1;
    ds_n_out  = 1'b1;
    rw_out    = 1'b1;
    addr_out  = 6'h00;
    wdata_out = 8'h5a;
  end

  // ----------------------------------------
  // One bus cycle, held until acknowledged or for 20 cycles at most
  // ----------------------------------------
  task automatic access(input logic rw, input logic [5:0] a, input logic [7:0] wd,
                        output logic [7:0] rd, output int lat, output logic oe_seen);
    int k;
    rd      = 8'h00;
    lat     = 99;
    oe_seen = 1'b0;
    cs_n_out  <= 1'b0;
    ds_n_out  <= 1'b0;
    rw_out    <= rw;
    addr_out  <= a;
    wdata_out <= rw ? ~wdata_out : wd;
    // Slow data memory answers are waited out
    for (k = 1; k <= 20; k++) begin
      @(posedge clk_in);
      if (ack_n_in === 1'b0) begin
        rd      = rdata_in;
        lat     = k - 1;
        oe_seen = oe_in;
        break;
      end
    end
    // Released bus carries the inverse, never the stale value
    cs_n_out  <= 1'b1;
    ds_n_out  <= 1'b1;
    wdata_out <= ~wd;
    for (k = 0; k < 4 && ack_n_in !== 1'b1; k++)
      @(posedge clk_in);
  endtask
endmodule

// ==== sim/tdm_switch_host_port_test.sv ====
// Self-checking bench of the switch host port
`timescale 1ns/1ps
module tdm_switch_host_port_test;
  logic        clk_in, reset_in, tick, frm, global_output_drive, dm_we, ack_n, oe, cs_n, ds_n, rw, ser, chk, frc, run;
  logic [7:0]  dm_wa, dm_wd, bus_out, wdata, sdrv, smsg, sdly;
  logic [5:0]  addr;
  logic [63:0] sbyte;
  logic [7:0]  connect_memory_high [256];
  logic [7:0]  connect_memory_low [256];
  logic [7:0]  dmm [256];
  int          failures, n_tests, seed, ph, bp, lp;

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  tdmhp_host_model tdmhp_host_model_inst (.clk_in(clk_in), .ack_n_in(ack_n), .oe_in(oe), .rdata_in(bus_out),
    .addr_out(addr), .wdata_out(wdata), .cs_n_out(cs_n), .ds_n_out(ds_n), .rw_out(rw));

  tdmhp_host_port tdmhp_host_port_inst (.clk_in(clk_in), .reset_in(reset_in), .host_address_inputs_in(addr),
    .host_data_bus_in(wdata), .host_data_bus_out(bus_out), .host_data_bus_oe_out(oe), .chip_select_n_in(cs_n),
    .data_strobe_n_in(ds_n), .read_write_in(rw), .data_acknowledge_n_out(ack_n), .tdm_bit_tick_in(tick),
    .frame_pulse_in(frm), .global_output_drive_in(global_output_drive), .dm_write_en_in(dm_we), .dm_write_addr_in(dm_wa),
    .dm_write_data_in(dm_wd), .serial_channel_control_out(ser), .stream_byte_out(sbyte),
    .stream_drive_en_out(sdrv), .stream_msg_mode_out(smsg), .stream_const_delay_out(sdly));

  // ----------------------------------------
  // Checking and expectations
  // ----------------------------------------
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic exp_ser(int p);
    return connect_memory_high[(p % 8) * 32 + (p / 8 + 1) % 32][1];
  endfunction

  function automatic logic [10:0] exp_out(int i);
    logic m;
    m = frc | connect_memory_high[i][2];
    return {m ? connect_memory_low[i] : dmm[connect_memory_low[i]], global_output_drive & (frc | connect_memory_high[i][0]), m, connect_memory_high[i][6]};
  endfunction

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic acc(input logic rw_i, input logic [5:0] a, input logic [7:0] wd, input int lim,
                     output logic [7:0] rd);
    int   lat;
    logic oe_s;
    tdmhp_host_model_inst.access(rw_i, a, wd, rd, lat, oe_s);
    cmp(lat <= lim, 1);
    cmp(oe_s, rw_i);
  endtask

  task automatic wctrl(input logic [7:0] v);
    logic [7:0] d;
    acc(1'b0, 6'h00, v, 8, d);
  endtask

  task automatic wfrm;
    do @(posedge clk_in); while (!(ph == 0 && bp == 0));
  endtask

  // ----------------------------------------
  // Bit ticks every fourth cycle and frame monitor
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (reset_in) begin
      ph = 0;
      bp = 0;
      lp = -1;
      tick <= 1'b0;
      frm  <= 1'b0;
    end else begin
      if (chk && ph == 3 && lp >= 0) begin
        cmp(ser, exp_ser(lp));
        if (lp % 8 == 0)
          for (int s = 0; s < 8; s++)
            cmp({sbyte[8*s+:8], sdrv[s], smsg[s], sdly[s]}, exp_out(s * 32 + lp / 8));
      end
      ph = (ph + 1) % 4;
      // Ticks wait until every memory word holds a known value
      tick <= run && (ph == 0);
      frm  <= run && (ph == 0 && bp == 0);
      if (ph == 0) begin
        lp = bp;
        bp = (bp + 1) % 256;
      end
    end
  end

  initial begin
    repeat (60000) @(posedge clk_in);
    failures++;
    end_sim();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] v, r;
    seed = 32'ha27c_8b8b;
    failures = 0;
    n_tests = 0;
    reset_in = 1'b1;
    {dm_we, chk, frc, run} = 4'h0;
    dm_wa = 8'h00;
    dm_wd = 8'h00;
    global_output_drive = 1'b1;
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    acc(1'b1, 6'h00, 8'h00, 8, r);
    cmp(r, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = 8'($random(seed));
      acc(1'b0, 6'h00, v, 8, r);
      acc(1'b1, {1'b0, i[2:0], 2'b00}, 8'h00, 8, r);
      cmp(r, v);
      acc(1'b1, {1'b0, i[2:0], 2'(i % 3 + 1)}, 8'h00, 8, r);
      cmp(r, 8'h00);
    end
    for (int i = 0; i < 256; i++) begin
      dmm[i] = 8'($random(seed));
      dm_we <= 1'b1;
      dm_wa <= i[7:0];
      dm_wd <= dmm[i];
      @(posedge clk_in);
    end
    dm_we <= 1'b0;
    for (int m = 2; m < 4; m++)
      for (int s = 0; s < 8; s++) begin
        wctrl({3'b000, m[1:0], s[2:0]});
        for (int c = 0; c < 32; c++) begin
          v = 8'($random(seed));
          acc(1'b0, {1'b1, c[4:0]}, v, 8, r);
          if (m == 3) connect_memory_high[s * 32 + c] = v;
          else connect_memory_low[s * 32 + c] = v;
        end
      end
    run = 1'b1;
    for (int m = 1; m < 4; m++)
      for (int s = 0; s < 8; s++) begin
        wctrl({3'b000, m[1:0], s[2:0]});
        for (int c = 0; c < 32; c++) begin
          acc(1'b1, {1'b1, c[4:0]}, 8'h00, (m == 1) ? 12 : 8, r);
          cmp(r, (m == 1) ? dmm[s * 32 + c] : (m == 2) ? connect_memory_low[s * 32 + c] : connect_memory_high[s * 32 + c]);
        end
      end
    wctrl(8'h0d);
    acc(1'b0, 6'h29, ~dmm[169], 12, r);
    acc(1'b1, 6'h29, 8'h00, 12, r);
    cmp(r, dmm[169]);
    wctrl(8'h05);
    acc(1'b0, 6'h29, 8'hff, 8, r);
    acc(1'b1, 6'h29, 8'h00, 8, r);
    cmp(r, 8'h00);
    wctrl(8'h9b);
    v = 8'($random(seed));
    acc(1'b0, 6'h27, v, 8, r);
    connect_memory_low[103] = v;
    acc(1'b1, 6'h27, 8'h00, 12, r);
    cmp(r, dmm[103]);
    wctrl(8'h13);
    acc(1'b1, 6'h27, 8'h00, 8, r);
    cmp(r, connect_memory_low[103]);
    wctrl(8'h1b);
    acc(1'b1, 6'h27, 8'h00, 8, r);
    cmp(r, connect_memory_high[103]);
    for (int k = 0; k < 4; k++) begin
      frc = k[0];
      wctrl({1'b0, k[0], 6'h00});
      global_output_drive <= ~k[1];
      wfrm();
      wfrm();
      chk = 1'b1;
      wfrm();
      chk = 1'b0;
    end
    end_sim();
  end
endmodule
